// ---- rtl/dpc_defines.vh ----
// constants of the dds pin control block
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DPC_ADDR_W     8
`define DPC_ACC_BITS   28
`define DPC_PH_BITS    12
`define DPC_WORD_BITS  16
`define DPC_CNT_BITS   16
`define DPC_WCNT_W     5
`define DPC_WORD_LAST  5'h0F
`define DPC_CTRL_W     6
`define DPC_STAT_W     7
`define DPC_PIN_W      8

// ----------------------------------------------------------------
// register byte offsets and word indices
// ----------------------------------------------------------------
`define DPC_OFF_CTRL   8'h00
`define DPC_OFF_FREQA  8'h04
`define DPC_OFF_FREQB  8'h08
`define DPC_OFF_PHA    8'h0C
`define DPC_OFF_PHB    8'h10
`define DPC_OFF_STAT   8'h14
`define DPC_OFF_SER    8'h18
`define DPC_OFF_PHOUT  8'h1C
`define DPC_IDX_CTRL   3'h0
`define DPC_IDX_FREQA  3'h1
`define DPC_IDX_FREQB  3'h2
`define DPC_IDX_PHA    3'h3
`define DPC_IDX_PHB    3'h4
`define DPC_IDX_STAT   3'h5
`define DPC_IDX_SER    3'h6
`define DPC_IDX_PHOUT  3'h7

// ----------------------------------------------------------------
// control and status bit positions
// ----------------------------------------------------------------
`define DPC_C_FPICK    0
`define DPC_C_PPICK    1
`define DPC_C_PINMODE  2
`define DPC_C_PD       3
`define DPC_C_LOEN     4
`define DPC_C_LOSRC    5
`define DPC_S_FREQ_WORD_PICK_BIT     0
`define DPC_S_PSEL     1
`define DPC_S_PD       2
`define DPC_S_INRST    3
`define DPC_S_NEW      4
`define DPC_S_OVR      5
`define DPC_S_ABORT    6

// ----------------------------------------------------------------
// pin bundle positions and reset values
// ----------------------------------------------------------------
`define DPC_PIN_SCLK   0
`define DPC_PIN_FRAME_SYNC_N  1
`define DPC_PIN_SERIAL_IN_LINE  2
`define DPC_PIN_FPICK  3
`define DPC_PIN_PPICK  4
`define DPC_PIN_RST    5
`define DPC_PIN_PD     6
`define DPC_PIN_COMP   7
`define DPC_PIN_INIT   8'h02
`define DPC_CTRL_RST   6'h00
`define DPC_FREQ_RST   28'h000_0000
`define DPC_PH_RST     12'h000
`define DPC_RESP_OK    2'b00
`define DPC_RESP_ERR   2'b10

`endif

// ---- rtl/dpc_sync.v ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module dpc_sync #(
  parameter         W    = 8,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] agree;

  // bits where stage two and three match
  assign agree = ~(s2_q ^ s3_q);

  // stage one is read only by stage two
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q    <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (s3_q & agree) | (q & ~agree);
    end
  end

endmodule // dpc_sync

// ---- rtl/dpc_serial_rx.v ----
// serial word receiver working on synchronised pin levels
`timescale 1ns/1ps
`include "dpc_defines.vh"

module dpc_serial_rx (
  input  wire                      aclk,
  input  wire                      aresetn,
  input  wire                      sclk_lvl,
  input  wire                      frame_sync_n_n_lvl,
  input  wire                      serial_in_line_lvl,
  output reg  [`DPC_WORD_BITS-1:0] word_q,
  output reg                       word_stb_q,
  output reg                       abort_stb_q
);

  localparam [`DPC_WCNT_W-1:0] LAST = `DPC_WORD_LAST;

  reg                      sclk_prev_q;
  reg [`DPC_WCNT_W-1:0]    cnt_q;
  reg [`DPC_WORD_BITS-1:0] shift_q;
  wire                     fall;
  wire [`DPC_WORD_BITS-1:0] shift_nx;

  // falling shift clock edge and next shift value, msb first
  assign fall     = sclk_prev_q & ~sclk_lvl;
  assign shift_nx = {shift_q[`DPC_WORD_BITS-2:0], serial_in_line_lvl};

  // bit counter and shifter
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_q <= 1'b0;
      cnt_q       <= {`DPC_WCNT_W{1'b0}};
      shift_q     <= {`DPC_WORD_BITS{1'b0}};
      word_q      <= {`DPC_WORD_BITS{1'b0}};
      word_stb_q  <= 1'b0;
      abort_stb_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_lvl;
      word_stb_q  <= 1'b0;
      abort_stb_q <= 1'b0;
      if (frame_sync_n_n_lvl) begin
        // frame idle: edges ignored, partial word dropped
        abort_stb_q <= (cnt_q != {`DPC_WCNT_W{1'b0}});
        cnt_q       <= {`DPC_WCNT_W{1'b0}};
      end else if (fall) begin
        // low frame sync means a word is loading
        shift_q <= shift_nx;
        if (cnt_q == LAST) begin
          word_q     <= shift_nx;
          word_stb_q <= 1'b1;
          cnt_q      <= {`DPC_WCNT_W{1'b0}};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule // dpc_serial_rx

// ---- rtl/dpc_top.v ----
// dds pin control top: axi4-lite registers, serial word load and nco datapath
`timescale 1ns/1ps
`include "dpc_defines.vh"
// What this block does
// - A serial frame carries one sixteen-bit word, one bit at a time on the data line.
// - One data bit is taken on every falling edge of the shift clock while frame sync is low.
// - The host pulls frame sync low to begin a word and the block treats that as a new load.
// - The frequency choice picks word a or word b as the accumulator step.
// - The frequency choice comes from its pin or from a control bit; the pin is static otherwise.
// - The phase choice picks offset a or offset b to add to the accumulator output.
// - The phase choice comes from its pin or from a control bit; the pin is static otherwise.
// - The active-high reset pin clears the datapath to zero, which is midscale at the converter.
// - The reset pin leaves the control, frequency and phase registers untouched.
// - The power-down pin powers the converter down just as the power-down bit does.
// - The logic output pin is driven only while its enable bit is one.
// - A source bit picks the comparator result or the accumulator msb for the logic output.
// - With enable and source both one the comparator is fed from the external input pin.
// - Output frequency is the selected word as a binary fraction of the master clock.
// - A 28-bit accumulator adds the selected step each clock and wraps over its full range.
// - Twelve-bit phase offsets add to the top accumulator bits, one cycle in 4096 per step.

module dpc_top #(
  parameter ACC_W = `DPC_ACC_BITS,
  parameter PH_W  = `DPC_PH_BITS
) (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [`DPC_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`DPC_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire                   shift_clk_pin,
  input  wire                   frame_sync_n,
  input  wire                   serial_in_line,
  input  wire                   freq_word_pick_pin,
  input  wire                   phase_word_pick_pin,
  input  wire                   dds_reset_pin,
  input  wire                   powerdown_pin,
  input  wire                   comparator_result,
  output wire [PH_W-1:0]        phase_code,
  output wire                   dac_powerdown,
  output wire                   logic_out,
  output wire                   logic_out_oe_n,
  output wire                   comparator_input_pin_sel
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg                        awready_q;
  reg                        wready_q;
  reg                        bvalid_q;
  reg  [1:0]                 bresp_q;
  reg                        arready_q;
  reg                        rvalid_q;
  reg  [31:0]                rdata_q;
  reg  [1:0]                 rresp_q;
  reg                        aw_hold_q;
  reg                        w_hold_q;
  reg  [`DPC_ADDR_W-1:0]     awaddr_q;
  reg  [31:0]                wdata_q;
  reg  [3:0]                 wstrb_q;
  reg  [`DPC_CTRL_W-1:0]     ctrl_q;
  reg  [ACC_W-1:0]           freq_word_a;
  reg  [ACC_W-1:0]           freq_word_b;
  reg  [PH_W-1:0]            phase_offset_a;
  reg  [PH_W-1:0]            phase_offset_b;
  reg                        word_new_q;
  reg                        overrun_q;
  reg                        abort_q;
  reg  [`DPC_CNT_BITS-1:0]   word_cnt_q;
  reg  [ACC_W-1:0]           acc_q;
  reg  [PH_W-1:0]            phase_code_q;
  reg                        dac_pd_q;
  reg                        logic_out_q;
  reg                        logic_out_oe_n_q;
  reg                        comp_pin_sel_q;
  wire [`DPC_PIN_W-1:0]      pins_raw;
  wire [`DPC_PIN_W-1:0]      pins_s;
  wire [`DPC_WORD_BITS-1:0]  rx_word;
  wire                       rx_stb;
  wire                       rx_abort;
  wire                       dp_reset;
  wire                       pin_mode;
  wire                       freq_word_pick_bit;
  wire                       phase_pick;
  wire                       freq_pick;
  wire [ACC_W-1:0]           freq_sel;
  wire [PH_W-1:0]            phase_sel;
  wire                       logic_out_enable;
  wire                       logic_out_source_sel;
  wire                       dac_powerdown_bit;
  wire [`DPC_STAT_W-1:0]     status_v;
  wire [3:0]                 wr_dec;
  wire [3:0]                 rd_dec;
  wire                       wr_fire;
  wire                       rd_fire;
  wire [31:0]                wr_merged;
  wire [`DPC_STAT_W-1:0]     w1c;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // byte offset to {hit, index}; anything else is unmapped
  function [3:0] dpc_decode;
    input [`DPC_ADDR_W-1:0] addr;
    begin
      case (addr)
        `DPC_OFF_CTRL:  dpc_decode = {1'b1, `DPC_IDX_CTRL};
        `DPC_OFF_FREQA: dpc_decode = {1'b1, `DPC_IDX_FREQA};
        `DPC_OFF_FREQB: dpc_decode = {1'b1, `DPC_IDX_FREQB};
        `DPC_OFF_PHA:   dpc_decode = {1'b1, `DPC_IDX_PHA};
        `DPC_OFF_PHB:   dpc_decode = {1'b1, `DPC_IDX_PHB};
        `DPC_OFF_STAT:  dpc_decode = {1'b1, `DPC_IDX_STAT};
        `DPC_OFF_SER:   dpc_decode = {1'b1, `DPC_IDX_SER};
        `DPC_OFF_PHOUT: dpc_decode = {1'b1, `DPC_IDX_PHOUT};
        default:        dpc_decode = {1'b0, `DPC_IDX_CTRL};
      endcase
    end
  endfunction

  // register contents as software sees them, upper bits zero except the word count in the serial register
  function [31:0] dpc_view;
    input [2:0] idx;
    begin
      case (idx)
        `DPC_IDX_CTRL:  dpc_view = {{(32-`DPC_CTRL_W){1'b0}}, ctrl_q};
        `DPC_IDX_FREQA: dpc_view = {{(32-ACC_W){1'b0}}, freq_word_a};
        `DPC_IDX_FREQB: dpc_view = {{(32-ACC_W){1'b0}}, freq_word_b};
        `DPC_IDX_PHA:   dpc_view = {{(32-PH_W){1'b0}}, phase_offset_a};
        `DPC_IDX_PHB:   dpc_view = {{(32-PH_W){1'b0}}, phase_offset_b};
        `DPC_IDX_STAT:  dpc_view = {{(32-`DPC_STAT_W){1'b0}}, status_v};
        `DPC_IDX_SER:   dpc_view = {word_cnt_q, rx_word};
        `DPC_IDX_PHOUT: dpc_view = {{(32-PH_W){1'b0}}, phase_code_q};
        default:        dpc_view = {32{1'b0}};
      endcase
    end
  endfunction

  // byte-lane merge of new data over old
  function [31:0] dpc_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        dpc_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and serial receiver
  // ----------------------------------------------------------------

  // gather the outside pins into one bundle
  assign pins_raw[`DPC_PIN_SCLK]  = shift_clk_pin;
  assign pins_raw[`DPC_PIN_FRAME_SYNC_N] = frame_sync_n;
  assign pins_raw[`DPC_PIN_SERIAL_IN_LINE] = serial_in_line;
  assign pins_raw[`DPC_PIN_FPICK] = freq_word_pick_pin;
  assign pins_raw[`DPC_PIN_PPICK] = phase_word_pick_pin;
  assign pins_raw[`DPC_PIN_RST]   = dds_reset_pin;
  assign pins_raw[`DPC_PIN_PD]    = powerdown_pin;
  assign pins_raw[`DPC_PIN_COMP]  = comparator_result;

  dpc_sync #(
    .W    (`DPC_PIN_W),
    .INIT (`DPC_PIN_INIT)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins_s)
  );

  dpc_serial_rx u_rx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sclk_lvl    (pins_s[`DPC_PIN_SCLK]),
    .frame_sync_n_n_lvl (pins_s[`DPC_PIN_FRAME_SYNC_N]),
    .serial_in_line_lvl   (pins_s[`DPC_PIN_SERIAL_IN_LINE]),
    .word_q      (rx_word),
    .word_stb_q  (rx_stb),
    .abort_stb_q (rx_abort)
  );

  // ----------------------------------------------------------------
  // selection logic
  // ----------------------------------------------------------------

  // control fields and pin or bit choice of words
  assign pin_mode             = ctrl_q[`DPC_C_PINMODE];
  assign freq_word_pick_bit   = ctrl_q[`DPC_C_FPICK];
  assign dac_powerdown_bit    = ctrl_q[`DPC_C_PD];
  assign logic_out_enable     = ctrl_q[`DPC_C_LOEN];
  assign logic_out_source_sel = ctrl_q[`DPC_C_LOSRC];
  assign freq_pick  = pin_mode ? pins_s[`DPC_PIN_FPICK] : freq_word_pick_bit;
  assign phase_pick = pin_mode ? pins_s[`DPC_PIN_PPICK] : ctrl_q[`DPC_C_PPICK];
  assign freq_sel   = freq_pick ? freq_word_b : freq_word_a;
  assign phase_sel  = phase_pick ? phase_offset_b : phase_offset_a;
  assign dp_reset   = pins_s[`DPC_PIN_RST];

  // status view
  assign status_v[`DPC_S_FREQ_WORD_PICK_BIT]  = freq_pick;
  assign status_v[`DPC_S_PSEL]  = phase_pick;
  assign status_v[`DPC_S_PD]    = dac_pd_q;
  assign status_v[`DPC_S_INRST] = dp_reset;
  assign status_v[`DPC_S_NEW]   = word_new_q;
  assign status_v[`DPC_S_OVR]   = overrun_q;
  assign status_v[`DPC_S_ABORT] = abort_q;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------

  // decode and write merge
  assign wr_dec    = dpc_decode(awaddr_q);
  assign rd_dec    = dpc_decode(s_axi_araddr);
  assign wr_fire   = aw_hold_q & w_hold_q & ~bvalid_q;
  assign rd_fire   = s_axi_arvalid & arready_q;
  assign wr_merged = dpc_merge(dpc_view(wr_dec[2:0]), wdata_q, wstrb_q);
  assign w1c = (wr_fire && wr_dec == {1'b1, `DPC_IDX_STAT} && wstrb_q[0]) ?
               wdata_q[`DPC_STAT_W-1:0] : {`DPC_STAT_W{1'b0}};

  // write channels, response, and the writable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q      <= 1'b1;
      wready_q       <= 1'b1;
      aw_hold_q      <= 1'b0;
      w_hold_q       <= 1'b0;
      awaddr_q       <= {`DPC_ADDR_W{1'b0}};
      wdata_q        <= {32{1'b0}};
      wstrb_q        <= 4'h0;
      bvalid_q       <= 1'b0;
      bresp_q        <= `DPC_RESP_OK;
      ctrl_q         <= `DPC_CTRL_RST;
      freq_word_a    <= `DPC_FREQ_RST;
      freq_word_b    <= `DPC_FREQ_RST;
      phase_offset_a <= `DPC_PH_RST;
      phase_offset_b <= `DPC_PH_RST;
    end else begin
      if (awready_q && s_axi_awvalid) begin
        awaddr_q  <= s_axi_awaddr;
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wready_q && s_axi_wvalid) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      // the datapath reset pin never reaches these registers
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_dec[3] ? `DPC_RESP_OK : `DPC_RESP_ERR;
        if (wr_dec[3]) begin
          case (wr_dec[2:0])
            `DPC_IDX_CTRL:  ctrl_q         <= wr_merged[`DPC_CTRL_W-1:0];
            `DPC_IDX_FREQA: freq_word_a    <= wr_merged[ACC_W-1:0];
            `DPC_IDX_FREQB: freq_word_b    <= wr_merged[ACC_W-1:0];
            `DPC_IDX_PHA:   phase_offset_a <= wr_merged[PH_W-1:0];
            `DPC_IDX_PHB:   phase_offset_b <= wr_merged[PH_W-1:0];
            default:        ctrl_q         <= ctrl_q;
          endcase
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read channel, one cycle to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= {32{1'b0}};
      rresp_q   <= `DPC_RESP_OK;
    end else begin
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_dec[3] ? dpc_view(rd_dec[2:0]) : {32{1'b0}};
        rresp_q   <= rd_dec[3] ? `DPC_RESP_OK : `DPC_RESP_ERR;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial word flags and count
  // ----------------------------------------------------------------

  // sticky flags: a new event wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      word_new_q <= 1'b0;
      overrun_q  <= 1'b0;
      abort_q    <= 1'b0;
      word_cnt_q <= {`DPC_CNT_BITS{1'b0}};
    end else begin
      if (rx_stb) begin
        word_new_q <= 1'b1;
        word_cnt_q <= word_cnt_q + 1'b1;
      end else if (w1c[`DPC_S_NEW] ||
                   (rd_fire && rd_dec == {1'b1, `DPC_IDX_SER})) begin
        word_new_q <= 1'b0;
      end
      if (rx_stb && word_new_q) begin
        overrun_q <= 1'b1;
      end else if (w1c[`DPC_S_OVR]) begin
        overrun_q <= 1'b0;
      end
      if (rx_abort) begin
        abort_q <= 1'b1;
      end else if (w1c[`DPC_S_ABORT]) begin
        abort_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // nco datapath
  // ----------------------------------------------------------------

  // accumulator steps by the selected word each clock and wraps
  always @(posedge aclk) begin
    if (!aresetn || dp_reset) begin
      acc_q        <= {ACC_W{1'b0}};
      phase_code_q <= {PH_W{1'b0}};
    end else begin
      acc_q        <= acc_q + freq_sel;
      phase_code_q <= acc_q[ACC_W-1 -: PH_W] + phase_sel;
    end
  end

  // ----------------------------------------------------------------
  // converter power and logic output pin
  // ----------------------------------------------------------------

  // pin and bit both power the converter down
  always @(posedge aclk) begin
    if (!aresetn) begin
      dac_pd_q         <= 1'b0;
      logic_out_q      <= 1'b0;
      logic_out_oe_n_q <= 1'b1;
      comp_pin_sel_q   <= 1'b0;
    end else begin
      dac_pd_q         <= pins_s[`DPC_PIN_PD] | dac_powerdown_bit;
      logic_out_oe_n_q <= ~logic_out_enable;
      logic_out_q      <= logic_out_enable &
                          (logic_out_source_sel ? pins_s[`DPC_PIN_COMP]
                                                : acc_q[ACC_W-1]);
      comp_pin_sel_q   <= logic_out_enable & logic_out_source_sel;
    end
  end

  // outputs straight from flops
  assign s_axi_awready            = awready_q;
  assign s_axi_wready             = wready_q;
  assign s_axi_bresp              = bresp_q;
  assign s_axi_bvalid             = bvalid_q;
  assign s_axi_arready            = arready_q;
  assign s_axi_rdata              = rdata_q;
  assign s_axi_rresp              = rresp_q;
  assign s_axi_rvalid             = rvalid_q;
  assign phase_code               = phase_code_q;
  assign dac_powerdown            = dac_pd_q;
  assign logic_out                = logic_out_q;
  assign logic_out_oe_n           = logic_out_oe_n_q;
  assign comparator_input_pin_sel = comp_pin_sel_q;

endmodule // dpc_top

// ---- sim/dpc_top_sva.sv ----
// assertion checker for the dds pin control top
`timescale 1ns/1ps
module dpc_top_sva #(
  parameter PH_W = 12
) (
  input wire logic            aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic            s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            powerdown_pin, dds_reset_pin, dac_powerdown,
  input wire logic            logic_out, logic_out_oe_n, comparator_input_pin_sel,
  input wire logic [PH_W-1:0] phase_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_b_after; s_wtake |-> ##2 s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while answering");
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_after: assert property (p_r_after) else $error("read answer late");
  property p_oe; logic_out_oe_n |-> !logic_out; endproperty
  a_oe: assert property (p_oe) else $error("logic out active while off");
  property p_csel; comparator_input_pin_sel |-> !logic_out_oe_n; endproperty
  a_csel: assert property (p_csel) else $error("comparator pin without enable");
  property p_pd; powerdown_pin [*8] |-> dac_powerdown; endproperty
  a_pd: assert property (p_pd) else $error("powerdown pin ignored");
  property p_rst; dds_reset_pin [*8] |-> phase_code == '0; endproperty
  a_rst: assert property (p_rst) else $error("datapath not cleared");
endmodule // dpc_top_sva

bind dpc_top dpc_top_sva #(.PH_W(PH_W)) chk (.*);

// ---- sim/dpc_host_model.sv ----
// serial host model driving the three-wire word load
`timescale 1ns/1ps
module dpc_host_model (
  output logic shift_clk_pin,
  output logic frame_sync_n,
  output logic serial_in_line
);
  // clock stands high outside frames
  initial begin
    shift_clk_pin = 1'b1;
    frame_sync_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // send the top n bits of w msb first, then close the frame
  task send(input logic [15:0] w, input int n);
    int i;
    #7;
    frame_sync_n = 1'b0;
    #160;
    for (i = 15; i > 15 - n; i--) begin
      shift_clk_pin = 1'b1;
      serial_in_line = w[i];
      #160;
      shift_clk_pin = 1'b0;
      #160;
    end
    shift_clk_pin = 1'b1;
    #160;
    frame_sync_n = 1'b1;
    serial_in_line = ~serial_in_line; // released line shows no stale bit
  endtask
endmodule // dpc_host_model

// ---- sim/dpc_top_bench.sv ----
// self-checking bench for the dds pin control top
`timescale 1ns/1ps
module dpc_top_bench;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        freq_word_pick_pin = 0, phase_word_pick_pin = 0, dds_reset_pin = 0;
  logic        powerdown_pin = 0, comparator_result = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         shift_clk_pin, frame_sync_n, serial_in_line, dac_powerdown, logic_out;
  wire         logic_out_oe_n, comparator_input_pin_sel;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [11:0]  phase_code;
  int          fails = 0, samples_checked = 0;
  dpc_top uut (.*);
  dpc_host_model hm (.*);
  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // axi write, both halves offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        b = 1;
        s_axi_bready <= 0;
        rs = s_axi_bresp;
      end
    end
  endtask
  task rdr(input logic [7:0] a);
    logic r;
    r = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        r = 1;
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
      end
    end
  endtask
  task t_bus_serial;
    wr(8'h04, 32'hFFFF_FFFF);
    rdr(8'h04);
    chk(rd, 32'h0FFF_FFFF);
    rdr(8'h20);
    chk({rd[29:0], rs}, 32'h0000_0002);
    wr(8'h24, 32'h0000_0001);
    chk(rs, 32'h0000_0002);
    hm.send(16'hA5C3, 16);
    cyc(10);
    rdr(8'h18);
    chk(rd, 32'h0001_A5C3);
    hm.send(16'hFFFF, 5);
    cyc(10);
    rdr(8'h14);
    chk(rd[6:4], 32'h0000_0004);
    $display("bus and serial done");
  endtask
  logic [3:0]  ctl [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
  logic [11:0] stp [4] = '{12'h010, 12'h020, 12'h020, 12'h010};
  task t_nco;
    int i;
    logic [11:0] p;
    wr(8'h04, 32'h0010_0000);
    wr(8'h08, 32'h0020_0000);
    for (i = 0; i < 4; i++) begin
      wr(8'h00, {28'h0, ctl[i]});
      freq_word_pick_pin <= (i == 2);
      cyc(8);
      p = phase_code;
      cyc(1);
      p = phase_code - p;
      chk(p, stp[i]);
    end
    $display("nco done");
  endtask
  task t_rst_phase;
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h0000_0123);
    wr(8'h00, 32'h0);
    dds_reset_pin <= 1;
    cyc(8);
    chk(phase_code, 32'h0);
    dds_reset_pin <= 0;
    rdr(8'h10);
    chk(rd, 32'h0000_0123);
    wr(8'h00, 32'h0000_0002);
    cyc(3);
    chk(phase_code, 32'h0000_0123);
    wr(8'h00, 32'h0000_0004);
    phase_word_pick_pin <= 1;
    cyc(8);
    chk(phase_code, 32'h0000_0123);
    $display("reset and phase done");
  endtask
  task t_pins;
    logic lo;
    comparator_result <= 1;
    powerdown_pin <= 1;
    wr(8'h00, 32'h0000_0030);
    cyc(8);
    chk({logic_out_oe_n, comparator_input_pin_sel, logic_out, dac_powerdown}, 32'h7);
    powerdown_pin <= 0;
    wr(8'h00, 32'h0000_0018);
    cyc(8);
    chk({logic_out_oe_n, comparator_input_pin_sel, logic_out, dac_powerdown}, 32'h1);
    // half-range step: accumulator msb flips every clock
    wr(8'h04, 32'h0800_0000);
    cyc(3);
    lo = logic_out;
    cyc(1);
    chk(logic_out ^ lo, 32'h1);
    wr(8'h00, 32'h0);
    cyc(3);
    chk({logic_out_oe_n, comparator_input_pin_sel, logic_out, dac_powerdown}, 32'h8);
    $display("pins done");
  endtask
  initial begin
    cyc(6);
    aresetn <= 1;
    t_bus_serial;
    t_nco;
    t_rst_phase;
    t_pins;
    wrap_up;
  end
  // watchdog against a hung handshake
  initial begin
    cyc(5000);
    fails++;
    wrap_up;
  end
endmodule // dpc_top_bench
